// file: rtl/pm_pkg.sv
// Package for the power-state sequencer: register map, fields, states, carriers.
// Assumes a 32-bit APB bus with byte addresses and one word per register.
package pm_pkg;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_TIME = 8'h04;
  localparam logic [7:0] A_GRP0 = 8'h08;
  localparam logic [7:0] A_VSET_A = 8'h20;
  localparam logic [7:0] A_VSET_B = 8'h24;
  localparam logic [7:0] A_SAVE_A = 8'h28;
  localparam logic [7:0] A_SAVE_B = 8'h2c;
  localparam logic [7:0] A_RAILS = 8'h30;
  localparam logic [7:0] A_CMD = 8'h34;
  localparam logic [7:0] A_STAT = 8'h38;
  // Control field positions
  localparam int C_TWAKE = 0;
  localparam int C_TRUNOFF = 1;
  localparam int C_WADAPT = 2;
  localparam int C_RESTORE = 3;
  localparam int C_LPIRQ = 4;
  localparam int C_AOD = 5;
  localparam int C_SER = 6;
  localparam int C_I2C = 8;
  localparam int C_BAUD = 15;
  localparam int C_LPDIS = 19;
  localparam int C_MINV = 24;
  // Rail vector: converters 0..7, regulators 1..3 in bits 8..10
  localparam int RAIL_W = 11;
  localparam int N_GRP = 6;
  localparam logic [10:0] LP_ALLOW = 11'h705;
  localparam logic [10:0] LP_BLOCK = 11'h0fa;
  localparam logic [1:0] SER_ALONE = 2'h0;
  localparam logic [6:0] LIM_FULL = 7'h64;
  localparam logic [6:0] LIM_LP = 7'h05;
  localparam int READY_S = 10;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] TIME_RST = 32'h0010_0010;

  typedef enum logic [5:0] {
    S_OFF = 6'h01,
    S_SD = 6'h02,
    S_LOAD = 6'h04,
    S_RDY = 6'h08,
    S_ACT = 6'h10,
    S_LP = 6'h20
  } pstate_e;

  typedef struct packed {
    logic backup_ok;
    logic main_ok;
    logic [7:0] vin_level;
    logic rtc_alarm;
    logic adapter_present;
    logic fault_sd;
    logic over_temp;
    logic shutdown_pin;
    logic ext_on_request_n;
    logic low_power_request_n;
    logic [5:1] rail_enable_in;
    logic power_good;
    logic cold_boot;
    logic irq_source;
    logic tick;
    logic cfg_done;
  } pm_in_s;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] vset_a;
    logic [23:0] vset_b;
  } nv_s;

  typedef struct packed {
    pstate_e state;
    logic rtc_on;
    logic vbat_on;
    logic vdd_on;
    logic wdt_on;
    logic serial_on;
    logic cfg_load_req;
    logic [1:0] pulse_freq_mode;
    logic [6:0] cur_limit_pct;
    logic [10:0] rails;
    logic [31:0] vset_a;
    logic [23:0] vset_b;
    logic [1:0] serial_type;
    logic [6:0] i2c_addr;
    logic [3:0] baud_sel;
    logic host_irq_n_o;
    logic host_irq_n_oe;
  } pm_out_s;
endpackage

// file: rtl/power_state_sequencer.sv
// Power-state sequencer with APB register file, one clock domain.
// Assumes pins synchronous to pclk and a one-cycle timebase tick input.
`timescale 1ns/1ps
`default_nettype none
module power_state_sequencer
  import pm_pkg::*;
#(
  parameter int TICK_HZ = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins, sensors and configuration store
  input wire pm_in_s pins,
  input wire nv_s nv,
  // Power control outputs
  output pm_out_s outs
);
  localparam logic [15:0] READY_TICKS = 16'(READY_S * TICK_HZ);

  typedef struct packed {
    pstate_e state;
    logic [31:0] ctrl;
    logic [31:0] tmo;
    logic [N_GRP-1:0][10:0] grp;
    logic [31:0] vset_a;
    logic [23:0] vset_b;
    logic [31:0] save_a;
    logic [23:0] save_b;
    logic saved_v;
    logic [10:0] rails;
    logic [5:1] en_q;
    logic ext_q;
    logic lpr_q;
    logic [15:0] cnt;
    logic [15:0] hold_cnt;
    logic [15:0] reset_out_timeout_cnt;
    logic reset_out_timeout_done;
    logic hold_pend;
    logic lp_want;
    logic irq_at;
    logic irq_gap;
    logic irq_lvl;
    logic irq_hi;
    logic [31:0] prdata;
    logic slverr;
  } st_s;

  st_s s_r;
  st_s s_nxt;
  logic [31:0] rd_val;
  logic rd_hit;
  logic wr;
  logic shut_cmd;
  logic ext_low;
  logic ext_fall;
  logic lpr_fall;
  logic lpr_rise;
  logic hold_hit;
  logic go_sd;
  logic edge_ok;
  logic rs_ok;
  logic wake;
  logic want_irq;

  assign wr = psel && penable && pwrite;
  assign shut_cmd = wr && (paddr == A_CMD) && pwdata[0];
  assign ext_low = !pins.ext_on_request_n;
  assign ext_fall = ext_low && !s_r.ext_q;
  assign lpr_fall = !pins.low_power_request_n && s_r.lpr_q;
  assign lpr_rise = pins.low_power_request_n && !s_r.lpr_q;
  assign hold_hit = s_r.hold_cnt >= s_r.tmo[15:0];
  assign rs_ok = ((s_r.rails & s_r.grp[0]) == s_r.grp[0]) && pins.power_good;
  assign want_irq = pins.irq_source && !s_r.irq_gap;

  ////////////////////////////////////////////////////////////////////////////
  // APB read decode
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    case (paddr)
      A_CTRL: rd_val = s_r.ctrl;
      A_TIME: rd_val = s_r.tmo;
      A_VSET_A: rd_val = s_r.vset_a;
      A_VSET_B: rd_val = {8'h00, s_r.vset_b};
      A_SAVE_A: rd_val = s_r.save_a;
      A_SAVE_B: rd_val = {8'h00, s_r.save_b};
      A_RAILS: rd_val = {21'h000000, s_r.rails};
      A_CMD: rd_val = '0;
      A_STAT: rd_val = {23'h000000, s_r.lp_want, outs.serial_on, s_r.saved_v, s_r.state};
      default: rd_hit = 1'b0;
    endcase
    for (int k = 0; k < N_GRP; k++) begin
      if (paddr == A_GRP0 + 8'(4 * k)) begin
        rd_val = {21'h000000, s_r.grp[k]};
        rd_hit = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_nxt = s_r;
    go_sd = 1'b0;
    wake = 1'b0;
    edge_ok = 1'b0;
    s_nxt.irq_gap = 1'b0;
    if (psel && !penable) begin
      s_nxt.prdata = rd_val;
      s_nxt.slverr = !rd_hit;
    end
    if (wr) begin
      case (paddr)
        A_CTRL: s_nxt.ctrl = pwdata;
        A_TIME: s_nxt.tmo = pwdata;
        A_VSET_A: s_nxt.vset_a = pwdata;
        A_VSET_B: s_nxt.vset_b = pwdata[23:0];
        A_RAILS: begin
          if (s_r.state inside {S_RDY, S_ACT, S_LP}) begin
            s_nxt.rails = pwdata[RAIL_W-1:0];
          end
        end
        default: ;
      endcase
      for (int k = 0; k < N_GRP; k++) begin
        if (paddr == A_GRP0 + 8'(4 * k)) begin
          s_nxt.grp[k] = pwdata[10:0];
        end
      end
    end
    s_nxt.en_q = pins.rail_enable_in;
    s_nxt.ext_q = ext_low;
    s_nxt.lpr_q = pins.low_power_request_n;
    // Rail enable pins act on edges only; dropped outside ready/active/low-power, and in low-power when the pin's LPDIS bit is set
    for (int k = 1; k <= 5; k++) begin
      edge_ok = (s_r.state inside {S_RDY, S_ACT}) ||
        (s_r.state == S_LP && !s_r.ctrl[C_LPDIS + k - 1]);
      if (edge_ok && pins.rail_enable_in[k] && !s_r.en_q[k]) begin
        s_nxt.rails = s_nxt.rails |
          ((s_r.state == S_LP) ? (s_r.grp[k] & LP_ALLOW) : s_r.grp[k]);
      end
      if (edge_ok && !pins.rail_enable_in[k] && s_r.en_q[k]) begin
        s_nxt.rails = s_nxt.rails & ~s_r.grp[k];
      end
    end
    // Hold-low timer on the external-on pin, counted in timebase ticks
    if (!ext_low) begin
      s_nxt.hold_cnt = '0;
    end else if (pins.tick && !hold_hit) begin
      s_nxt.hold_cnt = s_r.hold_cnt + 16'h0001;
    end
    if (s_r.hold_pend && (s_r.state inside {S_LOAD, S_RDY})) begin
      if (!ext_low) begin
        go_sd = 1'b1;
      end else if (hold_hit) begin
        s_nxt.hold_pend = 1'b0;
      end
    end
    unique case (s_r.state)
      S_OFF: begin
        s_nxt.state = S_SD;
      end
      S_SD: begin
        wake = pins.main_ok && (pins.rtc_alarm || ext_fall ||
          (pins.rail_enable_in[1] && !s_r.en_q[1] && !pins.cold_boot));
        if (pins.adapter_present && s_r.ctrl[C_WADAPT]) begin
          wake = 1'b1;
        end
        if (wake) begin
          s_nxt.state = S_LOAD;
          s_nxt.hold_pend = ext_fall && s_r.ctrl[C_TWAKE];
        end
      end
      S_LOAD: begin
        if (pins.cfg_done) begin
          s_nxt.ctrl = nv.ctrl;
          s_nxt.vset_a = nv.vset_a;
          s_nxt.vset_b = nv.vset_b;
          if (pins.vin_level > nv.ctrl[C_MINV +: 8]) begin
            s_nxt.state = S_RDY;
            s_nxt.cnt = '0;
            s_nxt.rails = s_nxt.rails | s_r.grp[0];
          end else begin
            go_sd = 1'b1;
          end
        end
      end
      S_RDY: begin
        if (pins.tick && s_r.cnt != 16'hffff) begin
          s_nxt.cnt = s_r.cnt + 16'h0001;
        end
        if (!pins.main_ok || pins.over_temp) begin
          go_sd = 1'b1;
        end else if (s_r.rails != '0 && !s_r.hold_pend) begin
          s_nxt.state = S_ACT;
          s_nxt.reset_out_timeout_cnt = '0;
          s_nxt.reset_out_timeout_done = 1'b0;
          if (s_r.ctrl[C_RESTORE] && s_r.saved_v) begin
            s_nxt.vset_a = s_r.save_a;
            s_nxt.vset_b = s_r.save_b;
          end
        end else if (s_r.cnt >= READY_TICKS && !pins.adapter_present) begin
          go_sd = 1'b1;
        end
      end
      S_ACT: begin
        if (!s_r.reset_out_timeout_done) begin
          if (!rs_ok) begin
            s_nxt.reset_out_timeout_cnt = '0;
          end else if (s_r.reset_out_timeout_cnt >= s_r.tmo[31:16]) begin
            s_nxt.reset_out_timeout_done = 1'b1;
          end else if (pins.tick) begin
            s_nxt.reset_out_timeout_cnt = s_r.reset_out_timeout_cnt + 16'h0001;
          end
        end
        if (lpr_fall && (s_r.rails[0] || s_r.rails[2])) begin
          s_nxt.lp_want = 1'b1;
          s_nxt.irq_at = pins.irq_source;
        end else if (lpr_rise) begin
          s_nxt.lp_want = 1'b0;
        end
        if ((s_r.rails == '0 && !s_r.ctrl[C_WADAPT]) || pins.fault_sd ||
            pins.over_temp) begin
          go_sd = 1'b1;
        end else if (shut_cmd || pins.shutdown_pin ||
            (s_r.ctrl[C_TRUNOFF] && ext_low && hold_hit)) begin
          go_sd = 1'b1;
        end else if (s_r.lp_want && (s_r.rails & LP_BLOCK) == '0) begin
          s_nxt.state = S_LP;
          s_nxt.lp_want = 1'b0;
          s_nxt.irq_gap = s_r.ctrl[C_LPIRQ] && s_r.irq_at;
        end
      end
      S_LP: begin
        if ((s_r.rails == '0 && !pins.adapter_present) || pins.fault_sd) begin
          go_sd = 1'b1;
        end else if (lpr_rise) begin
          s_nxt.state = S_ACT;
        end
      end
    endcase
    if (go_sd) begin
      if (s_r.state inside {S_ACT, S_LP}) begin
        s_nxt.save_a = s_r.vset_a;
        s_nxt.save_b = s_r.vset_b;
        s_nxt.saved_v = 1'b1;
      end
      s_nxt.state = S_SD;
      s_nxt.rails = '0;
      s_nxt.hold_pend = 1'b0;
      s_nxt.lp_want = 1'b0;
      s_nxt.reset_out_timeout_done = 1'b0;
    end
    if (!pins.backup_ok) begin
      s_nxt.state = S_OFF;
      s_nxt.rails = '0;
      s_nxt.hold_pend = 1'b0;
      s_nxt.lp_want = 1'b0;
      s_nxt.reset_out_timeout_done = 1'b0;
    end
    // Interrupt pin: drive high one cycle on release when active open-drain
    s_nxt.irq_lvl = want_irq;
    s_nxt.irq_hi = s_r.irq_lvl && !want_irq && s_r.ctrl[C_AOD];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.state <= S_OFF;
      s_r.ctrl <= CTRL_RST;
      s_r.tmo <= TIME_RST;
      s_r.ext_q <= 1'b0;
      s_r.lpr_q <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign prdata = s_r.prdata;
  assign pslverr = s_r.slverr;
  assign pready = 1'b1;
  assign outs.state = s_r.state;
  assign outs.rtc_on = s_r.state != S_OFF;
  assign outs.vbat_on = s_r.state != S_OFF;
  assign outs.vdd_on = s_r.state inside {S_LOAD, S_RDY, S_ACT, S_LP};
  assign outs.wdt_on = s_r.state inside {S_RDY, S_ACT};
  assign outs.serial_on = (s_r.ctrl[C_SER +: 2] != SER_ALONE) &&
    ((s_r.state == S_RDY) || (s_r.state == S_ACT && s_r.reset_out_timeout_done));
  assign outs.cfg_load_req = s_r.state == S_LOAD;
  assign outs.pulse_freq_mode = (s_r.state == S_LP) ? 2'h3 : 2'h0;
  assign outs.cur_limit_pct = (s_r.state == S_LP) ? LIM_LP : LIM_FULL;
  assign outs.rails = s_r.rails;
  assign outs.vset_a = s_r.vset_a;
  assign outs.vset_b = s_r.vset_b;
  assign outs.serial_type = s_r.ctrl[C_SER +: 2];
  assign outs.i2c_addr = s_r.ctrl[C_I2C +: 7];
  assign outs.baud_sel = s_r.ctrl[C_BAUD +: 4];
  assign outs.host_irq_n_o = !s_r.irq_lvl;
  assign outs.host_irq_n_oe = s_r.irq_lvl || s_r.irq_hi;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_run_to_sd;
    (s_r.state inside {S_ACT, S_LP}) ##1 (s_r.state == S_SD);
  endsequence

  sequence s_rdy_to_act;
    (s_r.state == S_RDY && s_r.ctrl[C_RESTORE] && s_r.saved_v) ##1 (s_r.state == S_ACT);
  endsequence

  a_batt_loss:
  assert property (!pins.backup_ok |=> s_r.state == S_OFF) else $error("no-power not entered");
  a_sd_domain:
  assert property (s_r.state == S_SD |-> outs.vbat_on && !outs.wdt_on && !outs.serial_on)
    else $error("shutdown gating wrong");
  a_alarm_wake:
  assert property (s_r.state == S_SD && pins.backup_ok && pins.main_ok && pins.rtc_alarm
    |=> s_r.state == S_LOAD) else $error("alarm did not wake");
  a_boot_reject:
  assert property (s_r.state == S_LOAD && pins.cfg_done && pins.backup_ok &&
    pins.vin_level <= nv.ctrl[C_MINV +: 8] |=> s_r.state == S_SD) else $error("low vin booted");
  a_ready_tmo:
  assert property (s_r.state == S_RDY && s_r.rails == '0 && s_r.cnt >= READY_TICKS &&
    !pins.adapter_present && pins.backup_ok |=> s_r.state == S_SD) else $error("ready timeout");
  a_sd_pin:
  assert property (s_r.state == S_ACT && pins.shutdown_pin && pins.backup_ok
    |=> s_r.state == S_SD) else $error("shutdown pin ignored");
  a_save_vset:
  assert property (s_run_to_sd |-> s_r.saved_v && s_r.save_a == $past(s_r.vset_a))
    else $error("settings not saved");
  a_lp_wait:
  assert property (s_r.state == S_ACT && (s_r.rails & LP_BLOCK) != '0 |=> s_r.state != S_LP)
    else $error("low-power entered early");
  a_lp_outputs:
  assert property (s_r.state == S_LP |-> outs.pulse_freq_mode == 2'h3 &&
    outs.cur_limit_pct == LIM_LP && !outs.serial_on) else $error("low-power outputs wrong");
  a_aod_pulse:
  assert property (outs.host_irq_n_o && outs.host_irq_n_oe
    |=> !(outs.host_irq_n_o && outs.host_irq_n_oe))
    else $error("high drive longer than one cycle");
  a_restore:
  assert property (s_rdy_to_act |-> s_r.vset_a == s_r.save_a) else $error("restore missing");
endmodule
`default_nettype wire

// file: sim/host_pins_model.sv
// Far-side model: host pin levels, battery timebase and configuration store.
// Assumes the bench sets pin levels in req; tick and cfg_done come from here.
`timescale 1ns/1ps
`default_nettype none
module host_pins_model
  import pm_pkg::*;
#(
  parameter int TICK_DIV = 4,
  parameter int CFG_WAIT = 3
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench pin levels and sequencer outputs
  input wire pm_in_s req,
  input wire pm_out_s outs,
  // Pins seen by the sequencer
  output pm_in_s pins
);
  int div_r;
  int cfg_r;
  logic tick_r;
  logic done_r;
  ////////////////////////////////////////////////////////////////////////////////
  // Timebase pulse and slow configuration answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 0;
      cfg_r <= 0;
      tick_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      div_r <= (div_r == TICK_DIV - 1) ? 0 : div_r + 1;
      tick_r <= (div_r == TICK_DIV - 1);
      cfg_r <= outs.cfg_load_req ? cfg_r + 1 : 0;
      done_r <= outs.cfg_load_req && (cfg_r >= CFG_WAIT);
    end
  end
  always_comb begin
    pins = req;
    pins.tick = tick_r;
    pins.cfg_done = done_r;
  end
endmodule
`default_nettype wire

// file: sim/power_state_sequencer_test.sv
// Self-checking bench of the power-state sequencer over APB and pins.
// Assumes pm_pkg, the sequencer and host_pins_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module power_state_sequencer_test
  import pm_pkg::*;
;
  localparam logic [31:0] NVC = {8'h40, 5'h0, 4'h3, 7'h2a, 2'h1, 6'h0};
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  pm_in_s req;
  pm_in_s pins;
  nv_s nv;
  pm_out_s outs;
  logic [31:0] rdat;
  logic rerr;
  int fails;
  int n_compared;
  int n;
  ////////////////////////////////////////////////////////////////////////////////
  power_state_sequencer #(.TICK_HZ(2)) power_state_sequencer_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins(pins), .nv(nv), .outs(outs)
  );
  host_pins_model host_pins_model_i (
    .pclk(pclk), .presetn(presetn), .req(req), .outs(outs), .pins(pins)
  );
  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    chk(32'(k < 50), 32'h1);
    if (k >= 50) finish_test();
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic wait_st(input pstate_e s);
    int k;
    k = 0;
    while (outs.state !== s && k < 2000) begin
      @(posedge pclk);
      k++;
    end
    chk(32'(outs.state), 32'(s));
    if (k >= 2000) finish_test();
  endtask
  task automatic wake_rtc();
    req.rtc_alarm <= 1'b1;
    @(posedge pclk);
    req.rtc_alarm <= 1'b0;
  endtask
  task automatic to_active();
    req.rail_enable_in <= '0;
    wake_rtc();
    wait_st(S_RDY);
    req.rail_enable_in[1] <= 1'b1;
    wait_st(S_ACT);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    fails = 0;
    n_compared = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    req = '0;
    req.backup_ok = 1'b1;
    req.main_ok = 1'b1;
    req.vin_level = 8'h20;
    req.ext_on_request_n = 1'b1;
    req.low_power_request_n = 1'b1;
    req.power_good = 1'b1;
    nv = '0;
    nv.ctrl = NVC;
    step(2);
    presetn <= 1'b1;
    step(2);
    chk(32'(outs.state), 32'(S_SD));
    chk(32'({outs.rtc_on, outs.vbat_on, outs.wdt_on, outs.serial_on}), 32'hc);
    rd_chk(A_CTRL, CTRL_RST);
    rd_chk(A_TIME, TIME_RST);
    rd_chk(8'h3c, 32'h0);
    chk(32'(rerr), 32'h1);
    wr(A_GRP0 + 8'h04, 32'h005);
    wr(A_GRP0 + 8'h08, 32'h002);
    wr(A_TIME, 32'h0008_0004);
    wake_rtc();
    wait_st(S_LOAD);
    chk(32'(outs.cfg_load_req), 32'h1);
    wait_st(S_SD);
    req.vin_level <= 8'h80;
    wake_rtc();
    wait_st(S_RDY);
    chk(32'({outs.wdt_on, outs.serial_on, outs.rails}), 32'h1800);
    chk(32'({outs.serial_type, outs.i2c_addr, outs.baud_sel}), 32'h0aa3);
    step(60);
    chk(32'(outs.state), 32'(S_RDY));
    wait_st(S_SD);
    to_active();
    chk(32'(outs.rails), 32'h005);
    step(16);
    chk(32'(outs.serial_on), 32'h0);
    step(40);
    chk(32'(outs.serial_on), 32'h1);
    req.rail_enable_in[2] <= 1'b1;
    step(4);
    chk(32'(outs.rails), 32'h007);
    req.low_power_request_n <= 1'b0;
    step(6);
    chk(32'(outs.state), 32'(S_ACT));
    req.rail_enable_in[2] <= 1'b0;
    wait_st(S_LP);
    chk(32'({outs.pulse_freq_mode, outs.cur_limit_pct}), 32'({2'h3, LIM_LP}));
    chk(32'({outs.wdt_on, outs.serial_on}), 32'h0);
    req.rail_enable_in[2] <= 1'b1;
    step(4);
    chk(32'(outs.rails), 32'h005);
    req.low_power_request_n <= 1'b1;
    wait_st(S_ACT);
    wr(A_VSET_A, 32'h0bad_cafe);
    req.low_power_request_n <= 1'b0;
    wait_st(S_LP);
    req.fault_sd <= 1'b1;
    wait_st(S_SD);
    req.fault_sd <= 1'b0;
    req.low_power_request_n <= 1'b1;
    rd_chk(A_SAVE_A, 32'h0bad_cafe);
    for (int k = 0; k < 5; k++) begin
      to_active();
      wr(A_VSET_A, 32'hc0de_0000 + 32'(k));
      case (k)
        0: req.shutdown_pin <= 1'b1;
        1: req.over_temp <= 1'b1;
        2: req.fault_sd <= 1'b1;
        3: wr(A_CMD, 32'h1);
        default: req.rail_enable_in <= '0;
      endcase
      wait_st(S_SD);
      req.shutdown_pin <= 1'b0;
      req.over_temp <= 1'b0;
      req.fault_sd <= 1'b0;
      rd_chk(A_SAVE_A, 32'hc0de_0000 + 32'(k));
    end
    req.backup_ok <= 1'b0;
    wait_st(S_OFF);
    req.backup_ok <= 1'b1;
    wait_st(S_SD);
    wr(A_CTRL, NVC | 32'h20);
    req.irq_source <= 1'b1;
    step(3);
    chk(32'({outs.host_irq_n_o, outs.host_irq_n_oe}), 32'h1);
    req.irq_source <= 1'b0;
    n = 0;
    while (!(outs.host_irq_n_o === 1'b1 && outs.host_irq_n_oe === 1'b1) && n < 10) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n < 10), 32'h1);
    @(posedge pclk);
    chk(32'(outs.host_irq_n_oe), 32'h0);
    req.cold_boot <= 1'b1;
    req.rail_enable_in <= 5'h01;
    step(8);
    chk(32'(outs.state), 32'(S_SD));
    req.ext_on_request_n <= 1'b0;
    wait_st(S_RDY);
    req.ext_on_request_n <= 1'b1;
    wait_st(S_SD);
    wr(A_CTRL, NVC | 32'h1);
    req.ext_on_request_n <= 1'b0;
    wait_st(S_RDY);
    req.ext_on_request_n <= 1'b1;
    step(2);
    chk(32'(outs.state), 32'(S_SD));
    req.adapter_present <= 1'b1;
    step(8);
    chk(32'(outs.state), 32'(S_SD));
    nv.ctrl <= NVC | 32'h4;
    wr(A_CTRL, NVC | 32'h4);
    wait_st(S_RDY);
    step(120);
    chk(32'(outs.state), 32'(S_RDY));
    req.adapter_present <= 1'b0;
    wait_st(S_SD);
    nv.ctrl <= NVC | 32'h18;
    to_active();
    chk(outs.vset_a, 32'hc0de_0004);
    req.irq_source <= 1'b1;
    req.low_power_request_n <= 1'b0;
    wait_st(S_LP);
    step(1);
    chk(32'(outs.host_irq_n_oe), 32'h0);
    step(1);
    chk(32'(outs.host_irq_n_oe), 32'h1);
    finish_test();
  end
endmodule
`default_nettype wire
